// *** logic/ptpc_edge.sv ***
// Pin synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none
module ptpc_edge
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous pin
    input wire logic pin_in,
    // Edge pulses, one cycle each
    output logic rise,
    output logic fall
);
    import ptpc_pkg::*;

    ptpc_sync_t sync_ff;
    ptpc_sync_t nxt_sync;

    // The meta stage feeds only the stable stage
    always_comb
    begin
        nxt_sync.meta = pin_in;
        nxt_sync.stable = sync_ff.meta;
        nxt_sync.last = sync_ff.stable;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sync_ff <= '0;
        else
            sync_ff <= nxt_sync;
    end

    assign rise = sync_ff.stable & ~sync_ff.last;
    assign fall = ~sync_ff.stable & sync_ff.last;
endmodule : ptpc_edge
`default_nettype wire

// *** logic/ptpc_pkg.sv ***
// Constants and types shared by the periodic timer pulse/capture block
package ptpc_pkg;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int STRB_W = 4;
    localparam int CNT_W = 10;
    localparam int PIN_N = 4;
    localparam int IRQ_W = 2;
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_P_BIT = 1;
    localparam int STAT_LANE = 0;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
    localparam logic [CNT_W-1:0] CNT_STEP = 10'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_COMPARE_A_VALUE = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_PERIOD_COMPARE_VALUE = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_COUNT = 8'h0c;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_MASK = 8'h14;
    localparam logic [1:0] MODE_CAPTURE = 2'b01;
    localparam logic [1:0] MODE_PULSE = 2'b10;
    localparam logic [1:0] PA_PULSE = 2'b11;
    localparam logic [1:0] PA_RISE = 2'b00;
    localparam logic [1:0] PA_FALL = 2'b01;
    localparam logic [1:0] PA_BOTH = 2'b10;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [CNT_W-1:0] COMPARE_A_VALUE_RST = 10'h000;
    localparam logic [CNT_W-1:0] PERIOD_COMPARE_VALUE_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    localparam logic [IRQ_W-1:0] STATUS_RST = 2'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

    typedef enum {REG_CTRL, REG_COMPARE_A_VALUE, REG_PERIOD_COMPARE_VALUE, REG_COUNT, REG_STATUS, REG_MASK, REG_NONE} ptpc_reg_t;

    typedef struct packed {
        logic cap_pin_sel;
        logic ext_pin_sel;
        logic counter_run_bit;
        logic output_polarity_invert;
        logic output_initial_level;
        logic capture_source_select;
        logic clear_source_select;
        logic pin_action_hi;
        logic pin_action_lo;
        logic mode_select_hi;
        logic mode_select_lo;
    } ptpc_ctrl_t;

    localparam ptpc_ctrl_t CTRL_RST = 11'h000;

    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } ptpc_sync_t;

    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic aw_got;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [AXI_DW-1:0] rdata;
        logic [AXI_AW-1:0] waddr;
        logic [AXI_DW-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
    } ptpc_axi_t;

    typedef struct packed {
        ptpc_axi_t axi;
        ptpc_ctrl_t ctrl;
        logic [CNT_W-1:0] compare_a_value;
        logic [CNT_W-1:0] period_compare_value;
        logic [CNT_W-1:0] cnt;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic irq;
        logic tm_out;
        logic tm_oe;
    } ptpc_state_t;
endpackage : ptpc_pkg

// *** logic/ptpc_top.sv ***
// Periodic timer single-pulse and capture modes behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
module ptpc_top
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ptpc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [ptpc_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [ptpc_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ptpc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [ptpc_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pins
    input wire logic ext_clock_pin_a,
    input wire logic ext_clock_pin_b,
    input wire logic capture_pin_a,
    input wire logic capture_pin_b,
    output logic tm_out,
    output logic tm_oe,
    // Interrupt
    output logic irq
);
    import ptpc_pkg::*;

    ptpc_state_t st_ff;
    ptpc_state_t nxt_st;

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_rise;
    logic [PIN_N-1:0] pin_fall;
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic ar_hs;
    logic r_hs;
    logic do_write;
    ptpc_reg_t wsel;
    ptpc_reg_t rsel;
    logic [AXI_DW-1:0] wmerged;
    logic [1:0] cur_action;
    logic pulse_mode;
    logic capture_mode;
    logic ext_edge;
    logic [1:0] cap_idx;
    logic cap_trig;
    logic match_a;
    logic period_hit;

    function automatic ptpc_reg_t decode(input logic [AXI_AW-1:0] addr);
        ptpc_reg_t r;
        case (addr)
            OFS_CTRL: r = REG_CTRL;
            OFS_COMPARE_A_VALUE: r = REG_COMPARE_A_VALUE;
            OFS_PERIOD_COMPARE_VALUE: r = REG_PERIOD_COMPARE_VALUE;
            OFS_COUNT: r = REG_COUNT;
            OFS_STATUS: r = REG_STATUS;
            OFS_MASK: r = REG_MASK;
            default: r = REG_NONE;
        endcase
        return r;
    endfunction : decode

    // Readback also serves as the base for strobed writes
    function automatic logic [AXI_DW-1:0] reg_value(input ptpc_reg_t r, input ptpc_state_t s);
        logic [AXI_DW-1:0] v;
        case (r)
            REG_CTRL: v = AXI_DW'(s.ctrl);
            REG_COMPARE_A_VALUE: v = AXI_DW'(s.compare_a_value);
            REG_PERIOD_COMPARE_VALUE: v = AXI_DW'(s.period_compare_value);
            REG_COUNT: v = AXI_DW'(s.cnt);
            REG_STATUS: v = AXI_DW'(s.status);
            REG_MASK: v = AXI_DW'(s.mask);
            default: v = '0;
        endcase
        return v;
    endfunction : reg_value

    function automatic logic [AXI_DW-1:0] lane_merge(
        input logic [AXI_DW-1:0] old,
        input logic [AXI_DW-1:0] data,
        input logic [STRB_W-1:0] strb
    );
        logic [AXI_DW-1:0] v;
        v = old;
        for (int i = 0; i < STRB_W; i++)
        begin
            if (strb[i])
                v[i*8 +: 8] = data[i*8 +: 8];
        end
        return v;
    endfunction : lane_merge

    function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] action);
        logic hit;
        case (action)
            PA_RISE: hit = r;
            PA_FALL: hit = f;
            PA_BOTH: hit = r | f;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // The live mode and the mode being written share one decode
    function automatic logic pulse_decode(input ptpc_ctrl_t c);
        logic [1:0] m;
        logic [1:0] a;
        m = {c.mode_select_hi, c.mode_select_lo};
        a = {c.pin_action_hi, c.pin_action_lo};
        // Pulse mode needs the pin action pair held at 11 by software
        return (m == MODE_PULSE) && (a == PA_PULSE);
    endfunction : pulse_decode

    function automatic logic capture_decode(input ptpc_ctrl_t c);
        logic [1:0] m;
        m = {c.mode_select_hi, c.mode_select_lo};
        return m == MODE_CAPTURE;
    endfunction : capture_decode

    // Polarity and initial level only matter while the pin is driven
    function automatic logic pulse_level(input ptpc_ctrl_t c, input logic run);
        logic v;
        v = (run ^ c.output_initial_level) ^ c.output_polarity_invert;
        return v;
    endfunction : pulse_level

    // Pins are sampled whatever their direction, so a driven edge counts too
    assign pin_raw = {capture_pin_b, capture_pin_a, ext_clock_pin_b, ext_clock_pin_a};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++)
        begin : g_pin
            ptpc_edge u_edge
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin_in(pin_raw[gi]),
                .rise(pin_rise[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    assign aw_hs = s_axi_awvalid & st_ff.axi.aw_rdy;
    assign w_hs = s_axi_wvalid & st_ff.axi.w_rdy;
    assign b_hs = st_ff.axi.bvalid & s_axi_bready;
    assign ar_hs = s_axi_arvalid & st_ff.axi.ar_rdy;
    assign r_hs = st_ff.axi.rvalid & s_axi_rready;
    // The response waits until both halves of a write are in
    assign do_write = st_ff.axi.aw_got & st_ff.axi.w_got & ~st_ff.axi.bvalid;
    assign wsel = decode(st_ff.axi.waddr);
    assign rsel = decode(s_axi_araddr);
    assign wmerged = lane_merge(reg_value(wsel, st_ff), st_ff.axi.wdata, st_ff.axi.wstrb);

    assign cur_action = {st_ff.ctrl.pin_action_hi, st_ff.ctrl.pin_action_lo};
    assign pulse_mode = pulse_decode(st_ff.ctrl);
    assign capture_mode = capture_decode(st_ff.ctrl);
    // Only a rising edge of the chosen clock pin triggers a pulse
    assign ext_edge = st_ff.ctrl.ext_pin_sel ? pin_rise[1] : pin_rise[0];
    // Capture pins sit at 2 and 3, external clock pins at 0 and 1
    assign cap_idx = {~st_ff.ctrl.capture_source_select, st_ff.ctrl.cap_pin_sel};
    assign cap_trig = edge_hit(pin_rise[cap_idx], pin_fall[cap_idx], cur_action);
    // Match needs the run bit, so a stopped counter cannot fire again
    assign match_a = st_ff.ctrl.counter_run_bit && (st_ff.cnt == st_ff.compare_a_value);
    // A zero period lets the counter run to its top value
    assign period_hit = (st_ff.period_compare_value == CNT_ZERO) ? (st_ff.cnt == CNT_MAX)
                                                 : (st_ff.cnt == st_ff.period_compare_value);

    always_comb
    begin
        logic run_old;
        logic run_new;
        logic pulse_new;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        run_old = 1'b0;
        run_new = 1'b0;
        pulse_new = 1'b0;
        ev = '0;
        clr = '0;
        nxt_st = st_ff;

        // Write channels are taken independently, then committed together
        if (aw_hs)
        begin
            nxt_st.axi.aw_got = 1'b1;
            nxt_st.axi.waddr = s_axi_awaddr;
        end
        if (w_hs)
        begin
            nxt_st.axi.w_got = 1'b1;
            nxt_st.axi.wdata = s_axi_wdata;
            nxt_st.axi.wstrb = s_axi_wstrb;
        end
        if (do_write)
        begin
            nxt_st.axi.aw_got = 1'b0;
            nxt_st.axi.w_got = 1'b0;
            nxt_st.axi.bvalid = 1'b1;
            nxt_st.axi.bresp = (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            case (wsel)
                REG_CTRL: nxt_st.ctrl = ptpc_ctrl_t'(wmerged[$bits(ptpc_ctrl_t)-1:0]);
                REG_COMPARE_A_VALUE: nxt_st.compare_a_value = wmerged[CNT_W-1:0];
                REG_PERIOD_COMPARE_VALUE: nxt_st.period_compare_value = wmerged[CNT_W-1:0];
                REG_STATUS: clr = st_ff.axi.wdata[IRQ_W-1:0] & {IRQ_W{st_ff.axi.wstrb[STAT_LANE]}};
                REG_MASK: nxt_st.mask = wmerged[IRQ_W-1:0];
                default: clr = '0;
            endcase
        end
        if (b_hs)
            nxt_st.axi.bvalid = 1'b0;

        if (ar_hs)
        begin
            nxt_st.axi.rvalid = 1'b1;
            nxt_st.axi.rdata = reg_value(rsel, st_ff);
            nxt_st.axi.rresp = (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (r_hs)
            nxt_st.axi.rvalid = 1'b0;

        // Timer core; hardware set of the run bit wins over a software clear
        run_old = st_ff.ctrl.counter_run_bit;
        run_new = nxt_st.ctrl.counter_run_bit;
        if (pulse_mode && ext_edge)
            run_new = 1'b1;
        if (pulse_mode && match_a)
        begin
            run_new = 1'b0;
            ev[IRQ_A_BIT] = 1'b1;
        end
        nxt_st.ctrl.counter_run_bit = run_new;

        if (!run_old && run_new)
            nxt_st.cnt = CNT_ZERO;
        else if (run_old && run_new && capture_mode)
        begin
            // Counting goes on regardless of pin activity
            if (period_hit)
            begin
                nxt_st.cnt = CNT_ZERO;
                ev[IRQ_P_BIT] = 1'b1;
            end
            else
                nxt_st.cnt = st_ff.cnt + CNT_STEP;
        end
        else if (run_old && run_new && pulse_mode)
            nxt_st.cnt = st_ff.cnt + CNT_STEP;

        // Capture overrides a software write to compare A in the same cycle
        if (capture_mode && cap_trig)
        begin
            nxt_st.compare_a_value = st_ff.cnt;
            ev[IRQ_A_BIT] = 1'b1;
        end

        nxt_st.status = (st_ff.status & ~clr) | ev;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);

        // Pin driven only in pulse mode; falling run bit is the trailing edge
        // Decoding the written mode lets enable and level move on the write edge
        pulse_new = pulse_decode(nxt_st.ctrl);
        nxt_st.tm_oe = pulse_new;
        if (pulse_new)
            nxt_st.tm_out = pulse_level(nxt_st.ctrl, run_new);
        else
            nxt_st.tm_out = 1'b0;

        nxt_st.axi.aw_rdy = ~nxt_st.axi.aw_got & ~nxt_st.axi.bvalid;
        nxt_st.axi.w_rdy = ~nxt_st.axi.w_got & ~nxt_st.axi.bvalid;
        nxt_st.axi.ar_rdy = ~nxt_st.axi.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RST;
            st_ff.compare_a_value <= COMPARE_A_VALUE_RST;
            st_ff.period_compare_value <= PERIOD_COMPARE_VALUE_RST;
            st_ff.cnt <= CNT_RST;
            st_ff.status <= STATUS_RST;
            st_ff.mask <= MASK_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign s_axi_awready = st_ff.axi.aw_rdy;
    assign s_axi_wready = st_ff.axi.w_rdy;
    assign s_axi_bvalid = st_ff.axi.bvalid;
    assign s_axi_bresp = st_ff.axi.bresp;
    assign s_axi_arready = st_ff.axi.ar_rdy;
    assign s_axi_rvalid = st_ff.axi.rvalid;
    assign s_axi_rdata = st_ff.axi.rdata;
    assign s_axi_rresp = st_ff.axi.rresp;
    assign tm_out = st_ff.tm_out;
    assign tm_oe = st_ff.tm_oe;
    assign irq = st_ff.irq;
endmodule : ptpc_top
`default_nettype wire

// *** test/ptpc_assertions.sv ***
// Bus handshake and timer output checks on the top ports
`timescale 1ns/10ps
`default_nettype none
module ptpc_assertions
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ptpc_pkg::AXI_DW-1:0] s_axi_rdata,
    // Timer outputs
    input wire logic tm_out,
    input wire logic tm_oe,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer off time");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed");
    // Drive enable moves only with a mode write
    oe_change_a: assert property ($changed(tm_oe) |-> $rose(s_axi_bvalid))
        else $error("pin enable moved without write");
    out_idle_a: assert property (!tm_oe |-> !tm_out)
        else $error("output active while undriven");
    irq_clear_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt dropped without write");
    cover property ($fell(tm_out) && tm_oe);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule : ptpc_assertions
bind ptpc_top ptpc_assertions u_chk
(
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .tm_out(tm_out), .tm_oe(tm_oe), .irq(irq)
);
`default_nettype wire

// *** test/ptpc_pins.sv ***
// Far-side model of the trigger and capture pins
`timescale 1ns/10ps
`default_nettype none
module ptpc_pins
(
    // Clock
    input wire logic aclk,
    // Pin levels: ext a, ext b, capture a, capture b
    output logic [3:0] lvl
);
    initial lvl = 4'h0;
    // Moves just after an edge; the level is always driven, never floats
    task set_pin(input int i, input logic v);
        @(posedge aclk);
        lvl[i] <= v;
    endtask : set_pin
endmodule : ptpc_pins
`default_nettype wire

// *** test/ptpc_top_test.sv ***
// Self-checking bench for the pulse and capture timer
`timescale 1ns/10ps
`default_nettype none
module ptpc_top_test;
    import ptpc_pkg::*;
    localparam logic [31:0] PUL = 32'h00e;
    localparam logic [31:0] RUN = 32'h100;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdat;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tm_out, tm_oe, irq;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] pin_lvl;
    int n_mismatch = 0, n_tests = 0, hi_n = 0;
    always #50 aclk = ~aclk;
    always @(posedge aclk) if (tm_out === 1'b1) hi_n <= hi_n + 1;
    ptpc_pins pins (.aclk(aclk), .lvl(pin_lvl));
    ptpc_top dut
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_clock_pin_a(pin_lvl[0]), .ext_clock_pin_b(pin_lvl[1]),
        .capture_pin_a(pin_lvl[2]), .capture_pin_b(pin_lvl[3]),
        .tm_out(tm_out), .tm_oe(tm_oe), .irq(irq)
    );
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        // Late ready keeps the answer standing for a cycle
        bready <= 1'b1;
        @(posedge aclk);
        chk("bresp", {30'h0, bresp}, {30'h0, r});
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        rdat = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, rdat, e);
    endtask : rc
    task t_regs;
        rc("ctrl", OFS_CTRL, 32'h0);
        rc("compare_a_value", OFS_COMPARE_A_VALUE, 32'h0);
        rc("period_compare_value", OFS_PERIOD_COMPARE_VALUE, 32'h0);
        rc("status", OFS_STATUS, 32'h0);
        rc("mask", OFS_MASK, 32'h0);
        rc("hole", 8'h18, 32'h0);
        chk("hole_resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(8'h18, 32'h1, RESP_SLVERR);
        wr(OFS_COUNT, 32'h55, RESP_OKAY);
        rc("count", OFS_COUNT, 32'h0);
    endtask : t_regs
    task t_pulse;
        int h;
        wr(OFS_MASK, 32'h3, RESP_OKAY);
        wr(OFS_COMPARE_A_VALUE, 32'h5, RESP_OKAY);
        wr(OFS_PERIOD_COMPARE_VALUE, 32'h2, RESP_OKAY);
        h = hi_n;
        wr(OFS_CTRL, PUL | RUN | 32'h10, RESP_OKAY);
        repeat (10) @(posedge aclk);
        chk("width", 32'(hi_n - h), 32'h6);
        rc("stop_count", OFS_COUNT, 32'h5);
        rc("run_clr", OFS_CTRL, PUL | 32'h10);
        rc("flags", OFS_STATUS, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(OFS_STATUS, 32'h1, RESP_OKAY);
        chk("irq_off", {31'h0, irq}, 32'h0);
    endtask : t_pulse
    task t_stop;
        logic [31:0] c;
        wr(OFS_COMPARE_A_VALUE, 32'h3ff, RESP_OKAY);
        wr(OFS_CTRL, PUL | RUN, RESP_OKAY);
        repeat (20) @(posedge aclk);
        chk("high", {31'h0, tm_out}, 32'h1);
        wr(OFS_CTRL, PUL, RESP_OKAY);
        chk("low", {31'h0, tm_out}, 32'h0);
        chk("oe", {31'h0, tm_oe}, 32'h1);
        rd(OFS_COUNT);
        c = rdat;
        repeat (5) @(posedge aclk);
        rc("held", OFS_COUNT, c);
        wr(OFS_CTRL, PUL | RUN, RESP_OKAY);
        rd(OFS_COUNT);
        chk("restart", {31'h0, rdat < c}, 32'h1);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
    endtask : t_stop
    task t_ext;
        int h;
        wr(OFS_COMPARE_A_VALUE, 32'h3, RESP_OKAY);
        wr(OFS_CTRL, PUL | 32'h200, RESP_OKAY);
        h = hi_n;
        pins.set_pin(0, 1'b1);
        repeat (12) @(posedge aclk);
        chk("other_pin", 32'(hi_n - h), 32'h0);
        pins.set_pin(1, 1'b1);
        repeat (12) @(posedge aclk);
        chk("ext_width", 32'(hi_n - h), 32'h4);
        rc("ext_flag", OFS_STATUS, 32'h1);
        pins.set_pin(0, 1'b0);
        pins.set_pin(1, 1'b0);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
    endtask : t_ext
    task t_cap;
        int p;
        // Output level bits set on purpose: they must do nothing here
        wr(OFS_PERIOD_COMPARE_VALUE, 32'h0, RESP_OKAY);
        wr(OFS_CTRL, 32'h1c1, RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CTRL, 32'h1c1 | 32'(i << 2) | 32'((i & 1) << 5), RESP_OKAY);
            wr(OFS_COMPARE_A_VALUE, 32'h0, RESP_OKAY);
            wr(OFS_STATUS, 32'h3, RESP_OKAY);
            p = (i & 1) ? 0 : 2;
            pins.set_pin(p, 1'b1);
            repeat (6) @(posedge aclk);
            rc("cap_rise", OFS_STATUS, {31'h0, i == 0 || i == 2});
            wr(OFS_STATUS, 32'h1, RESP_OKAY);
            pins.set_pin(p, 1'b0);
            repeat (6) @(posedge aclk);
            rc("cap_fall", OFS_STATUS, {31'h0, i == 1 || i == 2});
            rd(OFS_COMPARE_A_VALUE);
            chk("compare_a_value", {31'h0, rdat != 32'h0}, {31'h0, i != 3});
            chk("no_out", {30'h0, tm_oe, tm_out}, 32'h0);
        end
        rd(OFS_COUNT);
        p = int'(rdat);
        rd(OFS_COUNT);
        chk("free_run", {31'h0, int'(rdat) > p}, 32'h1);
    endtask : t_cap
    task t_period;
        wr(OFS_MASK, 32'h1, RESP_OKAY);
        wr(OFS_PERIOD_COMPARE_VALUE, 32'h3, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        wr(OFS_STATUS, 32'h3, RESP_OKAY);
        wr(OFS_CTRL, 32'h101, RESP_OKAY);
        repeat (20) @(posedge aclk);
        rd(OFS_COUNT);
        chk("bound", {31'h0, rdat <= 32'h3}, 32'h1);
        rc("per_flag", OFS_STATUS, 32'h2);
        chk("masked", {31'h0, irq}, 32'h0);
        wr(OFS_PERIOD_COMPARE_VALUE, 32'h0, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        wr(OFS_STATUS, 32'h2, RESP_OKAY);
        wr(OFS_CTRL, 32'h101, RESP_OKAY);
        repeat (500) @(posedge aclk);
        rc("no_wrap", OFS_STATUS, 32'h0);
        repeat (600) @(posedge aclk);
        rc("wrap", OFS_STATUS, 32'h2);
        wr(OFS_MASK, 32'h3, RESP_OKAY);
        chk("unmasked", {31'h0, irq}, 32'h1);
    endtask : t_period
    task stop_test;
        $display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    // Whole run is under two thousand cycles; allow ample margin
    initial
    begin
        #(20000 * 100);
        n_mismatch++;
        stop_test;
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_pulse;
        t_stop;
        t_ext;
        t_cap;
        t_period;
        stop_test;
    end
endmodule : ptpc_top_test
`default_nettype wire
